/* hw/mdio_user_pkg.sv */
// package: register map, field layout, reset values and contract of the user command block
// Contract
// - done of each command sets its raw event
// - raw event cleared by writing one
// - masked bit is raw event and mask
// - writing one to masked bit clears event
// - mask-enable write of one sets mask
// - mask-disable write of one clears mask
// - zero mask keeps interrupt off
// - command register layout: trigger, direction, ack, fields
// - trigger write-one-set, ack read-only, reset zero
// - trigger self-clears, blocks writes, needs enable
// - direction one writes, zero reads
// - ack and read data returned on read
package mdio_user_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int              ADDR_W         = 8;
    localparam int              DATA_W         = 32;
    localparam int              SEL_W          = 4;
    localparam int              CMD_COUNT      = 2;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]      OFF_RAW        = 8'h00;
    localparam logic [7:0]      OFF_MASKED     = 8'h04;
    localparam logic [7:0]      OFF_MASK_EN    = 8'h08;
    localparam logic [7:0]      OFF_MASK_DIS   = 8'h0C;
    localparam logic [7:0]      OFF_CMD0       = 8'h10;
    localparam logic [7:0]      OFF_CMD1       = 8'h14;
    localparam logic [7:0]      OFF_CTRL       = 8'h18;
    localparam logic [7:0]      OFF_STATUS     = 8'h1C;

    // ----------------------------------------------------------------
    // command register field layout
    // ----------------------------------------------------------------
    localparam int              CMD_GO_BIT     = 31;
    localparam int              CMD_DIR_BIT    = 30;
    localparam int              CMD_ACK_BIT    = 29;
    localparam int              CMD_REG_LSB    = 21;
    localparam int              CMD_PHY_LSB    = 16;
    localparam int              CMD_DATA_LSB   = 0;
    localparam int              FIELD_ADR_W    = 5;
    localparam int              FIELD_DATA_W   = 16;
    localparam logic [2:0]      CMD_RSVD_VALUE = 3'h0;

    // control register: bit 0 enables the serial engine
    localparam int              CTRL_EN_BIT    = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]      RAW_RESET      = 2'h0;
    localparam logic [1:0]      MASK_RESET     = 2'h0;
    localparam logic            ENABLE_RESET   = 1'h0;
    localparam logic [31:0]     DATA_RESET     = 32'h0000_0000;
    localparam logic [4:0]      ADR_RESET      = 5'h00;
    localparam logic [15:0]     WDATA_RESET    = 16'h0000;

endpackage

/* hw/user_command_slot.sv */
// one user command register with its trigger, direction, ack and fields
`timescale 1ns/1ns
`default_nettype none
module user_command_slot
(
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic                                   wr_i,
    input  wire logic [mdio_user_pkg::DATA_W-1:0]       wdata_i,
    input  wire logic [mdio_user_pkg::SEL_W-1:0]        sel_i,
    input  wire logic                                   enable_i,
    input  wire logic                                   done_i,
    input  wire logic                                   ack_i,
    input  wire logic [mdio_user_pkg::FIELD_DATA_W-1:0] rdata_i,
    output logic      [mdio_user_pkg::DATA_W-1:0]       value_o
);
    import mdio_user_pkg::*;

    typedef struct packed {
        logic                    go;
        logic                    dir;
        logic                    ack;
        logic [FIELD_ADR_W-1:0]  phy_reg_index;
        logic [FIELD_ADR_W-1:0]  phy_port_index;
        logic [FIELD_DATA_W-1:0] data;
    } slot_t;

    slot_t             cur;
    slot_t             next_cur;
    logic [DATA_W-1:0] byte_mask;
    logic [DATA_W-1:0] merged;

    // ----------------------------------------------------------------
    // register view and byte-lane merge
    // ----------------------------------------------------------------
    assign value_o   = {cur.go, cur.dir, cur.ack, CMD_RSVD_VALUE, cur.phy_reg_index,
                        cur.phy_port_index, cur.data};
    assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign merged    = (value_o & ~byte_mask) | (wdata_i & byte_mask);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        if (done_i)
        begin
            next_cur.go = 1'b0;
            if (!cur.dir)
            begin
                next_cur.ack = ack_i;
                if (ack_i)
                begin
                    next_cur.data = rdata_i;
                end
            end
        end
        else if (wr_i && !cur.go)
        begin
            next_cur.dir            = merged[CMD_DIR_BIT];
            next_cur.phy_reg_index  = merged[CMD_REG_LSB +: FIELD_ADR_W];
            next_cur.phy_port_index = merged[CMD_PHY_LSB +: FIELD_ADR_W];
            next_cur.data           = merged[CMD_DATA_LSB +: FIELD_DATA_W];
            if (merged[CMD_GO_BIT] && enable_i)
            begin
                next_cur.go  = 1'b1;
                next_cur.ack = 1'b0;
            end
        end
    end

    // state register, every field zero at reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

endmodule
`default_nettype wire

/* hw/mdio_user_command_interrupts.sv */
// wishbone register block for two user management commands and their interrupts
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mdio_user_command_interrupts
(
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    // wishbone classic slave
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [mdio_user_pkg::ADDR_W-1:0]       wb_adr_i,
    input  wire logic [mdio_user_pkg::SEL_W-1:0]        wb_sel_i,
    input  wire logic [mdio_user_pkg::DATA_W-1:0]       wb_dat_i,
    output logic      [mdio_user_pkg::DATA_W-1:0]       wb_dat_o,
    output logic                                        wb_ack_o,
    // serial engine request side
    output logic                                        eng_req_o,
    output logic                                        eng_write_o,
    output logic      [mdio_user_pkg::FIELD_ADR_W-1:0]  eng_phy_reg_index_o,
    output logic      [mdio_user_pkg::FIELD_ADR_W-1:0]  eng_phy_port_index_o,
    output logic      [mdio_user_pkg::FIELD_DATA_W-1:0] eng_wdata_o,
    output logic                                        eng_enable_o,
    input  wire logic                                   eng_done_i,
    input  wire logic                                   eng_ack_i,
    input  wire logic [mdio_user_pkg::FIELD_DATA_W-1:0] eng_rdata_i,
    // interrupt
    output logic                                        irq_o
);
    import mdio_user_pkg::*;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic {
        ARB_IDLE,
        ARB_RUN
    } arb_state_t;

    typedef struct packed {
        arb_state_t              state;
        logic                    owner;
        logic [CMD_COUNT-1:0]    raw;
        logic [CMD_COUNT-1:0]    mask;
        logic                    enable;
        logic                    ack;
        logic [DATA_W-1:0]       rdata;
        logic                    irq;
        logic                    eng_write;
        logic [FIELD_ADR_W-1:0]  eng_reg;
        logic [FIELD_ADR_W-1:0]  eng_phy;
        logic [FIELD_DATA_W-1:0] eng_wdata;
    } core_t;

    core_t                cur;
    core_t                next_cur;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic                 access;
    logic                 wr_access;
    logic [ADDR_W-1:0]    word_addr;
    logic                 lane0_wr;
    logic [CMD_COUNT-1:0] wr_bits;

    // a new request is taken once, in the cycle before ack rises
    assign access    = wb_cyc_i && wb_stb_i && !cur.ack;
    assign wr_access = access && wb_we_i;
    assign word_addr = {wb_adr_i[ADDR_W-1:2], 2'h0};
    assign lane0_wr  = wr_access && wb_sel_i[0];
    assign wr_bits   = wb_dat_i[CMD_COUNT-1:0];

    // ----------------------------------------------------------------
    // command slots
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]    slot_value [CMD_COUNT];
    logic [CMD_COUNT-1:0] slot_go;
    logic [CMD_COUNT-1:0] slot_wr;
    logic [CMD_COUNT-1:0] slot_done;
    logic                 run;

    assign run = (cur.state == ARB_RUN);

    genvar gi;
    generate
        for (gi = 0; gi < CMD_COUNT; gi++)
        begin : g_slot
            localparam logic [ADDR_W-1:0] SLOT_OFF = (gi == 0) ? OFF_CMD0 : OFF_CMD1;

            // write strobe for this slot and its completion pulse
            assign slot_wr[gi]   = wr_access && (word_addr == SLOT_OFF);
            assign slot_done[gi] = run && eng_done_i && (cur.owner == 1'(gi));
            assign slot_go[gi]   = slot_value[gi][CMD_GO_BIT];

            user_command_slot u_slot
            (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .wr_i     (slot_wr[gi]),
                .wdata_i  (wb_dat_i),
                .sel_i    (wb_sel_i),
                .enable_i (cur.enable),
                .done_i   (slot_done[gi]),
                .ack_i    (eng_ack_i),
                .rdata_i  (eng_rdata_i),
                .value_o  (slot_value[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // event, mask and clear terms
    // ----------------------------------------------------------------
    logic [CMD_COUNT-1:0] raw_clear;
    logic [CMD_COUNT-1:0] mask_set;
    logic [CMD_COUNT-1:0] mask_clear;
    logic [CMD_COUNT-1:0] masked;

    // writing one to the raw or the masked view drops the event
    assign raw_clear  = ({CMD_COUNT{lane0_wr && (word_addr == OFF_RAW)}} & wr_bits)
                      | ({CMD_COUNT{lane0_wr && (word_addr == OFF_MASKED)}} & wr_bits);
    assign mask_set   = {CMD_COUNT{lane0_wr && (word_addr == OFF_MASK_EN)}} & wr_bits;
    assign mask_clear = {CMD_COUNT{lane0_wr && (word_addr == OFF_MASK_DIS)}} & wr_bits;
    assign masked     = cur.raw & cur.mask;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_cur     = cur;
        next_cur.ack = access;

        // sticky events; a completion in the clearing cycle survives
        next_cur.raw  = (cur.raw & ~raw_clear) | slot_done;
        next_cur.mask = (cur.mask | mask_set) & ~mask_clear;
        next_cur.irq  = |(next_cur.raw & next_cur.mask);

        // control register: engine enable
        if (wr_access && wb_sel_i[0] && (word_addr == OFF_CTRL))
        begin
            next_cur.enable = wb_dat_i[CTRL_EN_BIT];
        end

        // read data captured with the request
        if (access && !wb_we_i)
        begin
            unique case (word_addr)
                OFF_RAW:
                begin
                    next_cur.rdata = {30'h0000_0000, cur.raw};
                end
                OFF_MASKED:
                begin
                    next_cur.rdata = {30'h0000_0000, masked};
                end
                OFF_MASK_EN,
                OFF_MASK_DIS:
                begin
                    next_cur.rdata = {30'h0000_0000, cur.mask};
                end
                OFF_CMD0:
                begin
                    next_cur.rdata = slot_value[0];
                end
                OFF_CMD1:
                begin
                    next_cur.rdata = slot_value[1];
                end
                OFF_CTRL:
                begin
                    next_cur.rdata = {31'h0000_0000, cur.enable};
                end
                OFF_STATUS:
                begin
                    next_cur.rdata = {29'h0000_0000, run, slot_go};
                end
                default:
                begin
                    next_cur.rdata = DATA_RESET;
                end
            endcase
        end

        // arbiter: slot zero first, one command on the engine at a time
        unique case (cur.state)
            ARB_IDLE:
            begin
                if (slot_go[0] || slot_go[1])
                begin
                    next_cur.state     = ARB_RUN;
                    next_cur.owner     = !slot_go[0];
                    next_cur.eng_write = slot_value[!slot_go[0]][CMD_DIR_BIT];
                    next_cur.eng_reg   =
                        slot_value[!slot_go[0]][CMD_REG_LSB +: FIELD_ADR_W];
                    next_cur.eng_phy   =
                        slot_value[!slot_go[0]][CMD_PHY_LSB +: FIELD_ADR_W];
                    next_cur.eng_wdata =
                        slot_value[!slot_go[0]][CMD_DATA_LSB +: FIELD_DATA_W];
                end
            end
            ARB_RUN:
            begin
                if (eng_done_i)
                begin
                    next_cur.state = ARB_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur           <= '0;
            cur.state     <= ARB_IDLE;
            cur.raw       <= RAW_RESET;
            cur.mask      <= MASK_RESET;
            cur.enable    <= ENABLE_RESET;
            cur.rdata     <= DATA_RESET;
            cur.eng_reg   <= ADR_RESET;
            cur.eng_phy   <= ADR_RESET;
            cur.eng_wdata <= WDATA_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o             = cur.ack;
    assign wb_dat_o             = cur.rdata;
    assign eng_req_o            = run;
    assign eng_write_o          = cur.eng_write;
    assign eng_phy_reg_index_o  = cur.eng_reg;
    assign eng_phy_port_index_o = cur.eng_phy;
    assign eng_wdata_o          = cur.eng_wdata;
    assign eng_enable_o         = cur.enable;
    assign irq_o                = cur.irq;

endmodule
`default_nettype wire

/* testbench/mdio_user_properties.sv */
// checker: port timing relations of the user command register block
`timescale 1ns/1ns
`default_nettype none
module mdio_user_checker
    import mdio_user_pkg::*;
(
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [ADDR_W-1:0]       wb_adr_i,
    input wire logic [SEL_W-1:0]        wb_sel_i,
    input wire logic [DATA_W-1:0]       wb_dat_i,
    input wire logic [DATA_W-1:0]       wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire logic                    eng_req_o,
    input wire logic                    eng_write_o,
    input wire logic [FIELD_ADR_W-1:0]  eng_phy_reg_index_o,
    input wire logic [FIELD_ADR_W-1:0]  eng_phy_port_index_o,
    input wire logic [FIELD_DATA_W-1:0] eng_wdata_o,
    input wire logic                    eng_enable_o,
    input wire logic                    eng_done_i,
    input wire logic                    eng_ack_i,
    input wire logic [FIELD_DATA_W-1:0] eng_rdata_i,
    input wire logic                    irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic tk;
    logic fin;
    logic clr;
    // write taken, command finished, clearing write of both bits
    assign tk = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign fin = eng_req_o && eng_done_i;
    assign clr = tk && wb_sel_i[0] && wb_dat_i[1:0] == 2'h3 && !eng_done_i
        && (wb_adr_i == OFF_RAW || wb_adr_i == OFF_MASKED || wb_adr_i == OFF_MASK_DIS);
    req_drop_a: assert property (fin |=> !eng_req_o)
        else $error("engine request held after completion");
    req_hold_a: assert property (eng_req_o && !eng_done_i |=> eng_req_o
        && $stable(eng_write_o) && $stable(eng_phy_reg_index_o)
        && $stable(eng_phy_port_index_o) && $stable(eng_wdata_o))
        else $error("engine request changed before completion");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
        !irq_o && !eng_req_o && !eng_enable_o && !wb_ack_o)
        else $error("outputs active after reset");
    req_enable_a: assert property ($rose(eng_req_o) |-> eng_enable_o)
        else $error("command started while engine disabled");
    enable_write_a: assert property ($changed(eng_enable_o) |-> $past(tk))
        else $error("engine enable changed without a write");
    irq_rise_a: assert property ($rose(irq_o) |->
        $past(fin) || $past(fin, 2) || $past(tk) || $past(tk, 2))
        else $error("interrupt rose without completion or mask write");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(tk) || $past(tk, 2))
        else $error("interrupt fell without a write");
    irq_clear_a: assert property (clr |=> ##[0:1] !irq_o)
        else $error("interrupt stayed after clearing write");
endmodule
bind mdio_user_command_interrupts mdio_user_checker i_mdio_user_checker
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .eng_req_o(eng_req_o), .eng_write_o(eng_write_o),
    .eng_phy_reg_index_o(eng_phy_reg_index_o), .eng_phy_port_index_o(eng_phy_port_index_o),
    .eng_wdata_o(eng_wdata_o), .eng_enable_o(eng_enable_o), .eng_done_i(eng_done_i),
    .eng_ack_i(eng_ack_i), .eng_rdata_i(eng_rdata_i), .irq_o(irq_o)
);
`default_nettype wire

/* testbench/phy_engine_model.sv */
// behavioural serial engine and phy: answers each command after a set latency
`timescale 1ns/1ns
`default_nettype none
module phy_engine_model
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [4:0]  reg_index_i,
    input  wire logic [4:0]  port_index_i,
    input  wire logic [7:0]  latency_i,
    input  wire logic        nack_i,
    output logic             done_o,
    output logic             ack_o,
    output logic [15:0]      rdata_o
);
    logic [7:0] count;
    // count latency, pulse done once; ack and data toggle outside a completion
    always_ff @(posedge clk_i)
    begin
        done_o <= 1'b0;
        ack_o <= ~ack_o;
        rdata_o <= ~rdata_o;
        if (rst_i || !req_i)
            count <= 8'h00;
        else if (!done_o && count == latency_i)
        begin
            done_o <= 1'b1;
            ack_o <= !nack_i;
            rdata_o <= nack_i ? ~rdata_o : {port_index_i, reg_index_i, 6'h2B};
            count <= 8'h00;
        end
        else if (!done_o)
            count <= count + 8'h01;
        if (rst_i)
        begin
            ack_o <= 1'b0;
            rdata_o <= 16'hA5A5;
        end
    end
endmodule
`default_nettype wire

/* testbench/mdio_user_command_interrupts_bench.sv */
// self-checking bench: register traffic, user commands and the interrupt
`timescale 1ns/1ns
`default_nettype none
module mdio_user_command_interrupts_bench;
    import mdio_user_pkg::*;
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    wb_cyc_i = 1'b0;
    logic                    wb_stb_i = 1'b0;
    logic                    wb_we_i = 1'b0;
    logic [ADDR_W-1:0]       wb_adr_i = 8'h00;
    logic [SEL_W-1:0]        wb_sel_i = 4'hF;
    logic [DATA_W-1:0]       wb_dat_i = 32'h0000_0000;
    logic [DATA_W-1:0]       wb_dat_o;
    logic                    wb_ack_o;
    logic                    eng_req_o;
    logic                    eng_write_o;
    logic [FIELD_ADR_W-1:0]  reg_ix;
    logic [FIELD_ADR_W-1:0]  port_ix;
    logic [FIELD_DATA_W-1:0] eng_wdata_o;
    logic                    eng_enable_o;
    logic                    done;
    logic                    ack;
    logic [FIELD_DATA_W-1:0] rdata;
    logic                    irq_o;
    logic [7:0]              latency = 8'h08;
    logic                    nack = 1'b0;
    logic                    req_d = 1'b0;
    logic [31:0]             rd_q[$];
    logic [26:0]             eng_q[$];
    int                      num_errors = 0;
    int                      samples_checked = 0;
    mdio_user_command_interrupts i_mdio_user_command_interrupts (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .eng_req_o(eng_req_o), .eng_write_o(eng_write_o), .eng_phy_reg_index_o(reg_ix),
        .eng_phy_port_index_o(port_ix), .eng_wdata_o(eng_wdata_o), .eng_enable_o(eng_enable_o),
        .eng_done_i(done), .eng_ack_i(ack), .eng_rdata_i(rdata), .irq_o(irq_o));
    phy_engine_model i_phy_engine_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(eng_req_o),
        .reg_index_i(reg_ix), .port_index_i(port_ix), .latency_i(latency), .nack_i(nack),
        .done_o(done), .ack_o(ack), .rdata_o(rdata));
    always #25 clk_i = ~clk_i;
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read answers and engine requests are taken off the queues as they appear
    always @(posedge clk_i)
    begin
        req_d <= eng_req_o;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk(wb_dat_o, rd_q.pop_front());
        if (eng_req_o === 1'b1 && req_d === 1'b0)
            chk({5'h0, eng_write_o, reg_ix, port_ix, eng_wdata_o}, {5'h0, eng_q.pop_front()});
    end
    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20)
            num_errors++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(a, 1'b0, 32'h0000_0000);
    endtask
    // wait for the running command to finish
    task automatic wait_cmd();
        int n;
        n = 0;
        repeat (2) @(posedge clk_i);
        while (eng_req_o === 1'b1 && n < 100)
        begin
            n++;
            @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, {31'h0, e});
    endtask
    task automatic final_report();
        $display("num_errors=%0d samples_checked=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        num_errors++;
        final_report();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] c;
        logic [4:0]  ra;
        logic [4:0]  pa;
        logic [15:0] wd;
        logic        dir;
        logic        ak;
        int          slot;
        void'($urandom(51175));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
        wr(OFF_CMD0, 32'hFFFF_FFFF);
        rd(OFF_CMD0, 32'h43FF_FFFF);
        wr(OFF_CTRL, 32'h1);
        rd(OFF_CTRL, 32'h1);
        wr(OFF_MASK_EN, 32'h1);
        wr(OFF_MASK_EN, 32'h0);
        rd(OFF_MASK_DIS, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            slot = i % 2;
            dir = i[1];
            ra = 5'($urandom);
            pa = 5'($urandom);
            wd = 16'($urandom);
            latency <= 8'(8 + $urandom % 16);
            nack <= (i == 4);
            ak = !dir && i != 4;
            c = {1'b1, dir, 1'b0, 3'h0, ra, pa, wd};
            eng_q.push_back({dir, c[25:0]});
            wr(OFF_CMD0 + 8'(4 * slot), c);
            wr(OFF_CMD0 + 8'(4 * slot), ~c);
            rd(OFF_STATUS, 32'(4 + (1 << slot)));
            wait_cmd();
            rd(OFF_CMD0 + 8'(4 * slot), {1'b0, dir, ak, 3'h0, ra, pa, ak ? {pa, ra, 6'h2B} : wd});
            wr(OFF_RAW, 32'h0);
            rd(OFF_RAW, 32'(1 << slot));
            rd(OFF_MASKED, (slot == 0) ? 32'h1 : 32'h0);
            irq_is(slot == 0);
            wr(i[2] ? OFF_MASKED : OFF_RAW, 32'h3);
            rd(OFF_RAW, 32'h0);
        end
        wr(OFF_MASK_DIS, 32'h1);
        rd(OFF_MASK_EN, 32'h0);
        eng_q.push_back(27'h0);
        wr(OFF_CMD1, 32'h8000_0000);
        wait_cmd();
        irq_is(1'b0);
        wr(OFF_MASK_EN, 32'h2);
        irq_is(1'b1);
        rd(OFF_MASKED, 32'h2);
        wr(OFF_MASK_DIS, 32'h3);
        irq_is(1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFF_RAW, 32'h0);
        rd(OFF_CTRL, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
